// [extop_pkg.sv]
/*
 Constants shared by the extended skip, table-read and exclusive-OR execution unit.
 Assumes an 8-bit core with a 16-bit program word and an external instruction sequencer.
*/
package extop_pkg;
   // ***************************************************************
   // Operation codes presented by the decoder
   // ***************************************************************
   typedef enum logic [3:0] {
      EXTOP_NONE = 4'h0,
      EXTOP_SKIP_IF_ZERO = 4'h1,
      EXTOP_SKIP_IF_ZERO_MOVE = 4'h2,
      EXTOP_SKIP_BIT_ZERO = 4'h3,
      EXTOP_TABLE_READ_PAGE = 4'h4,
      EXTOP_TABLE_READ_LAST_PAGE = 4'h5,
      EXTOP_TABLE_READ_PAGE_PREINC = 4'h6,
      EXTOP_TABLE_READ_LAST_PREINC = 4'h7,
      EXTOP_XOR_TO_ACCUM = 4'h8,
      EXTOP_XOR_TO_MEMORY = 4'h9,
      EXTOP_NIBBLE_SWAP_TO_ACCUM = 4'ha
   } extop_op_t;

   typedef enum logic [1:0] {
      EXTOP_IDLE = 2'h0,
      EXTOP_TABLE_WAIT = 2'h1,
      EXTOP_SKIP_DUMMY = 2'h2
   } extop_state_t;

   // ***************************************************************
   // Reset values and cycle counts
   // ***************************************************************
   localparam logic [7:0] EXTOP_ACC_RESET = 8'h00;
   localparam logic [7:0] EXTOP_PTR_RESET = 8'h00;
   localparam logic [7:0] EXTOP_TABLE_HIGH_BYTE_REG_RESET = 8'h00;
   localparam logic EXTOP_ZERO_RESET = 1'b0;
   localparam int EXTOP_SKIP_CYCLES = 3;
   localparam int EXTOP_PLAIN_CYCLES = 1;
   localparam int EXTOP_TABLE_CYCLES = 2;
endpackage : extop_pkg

// [extop_unit.sv]
/*
 Execution unit for zero skips, table reads, exclusive-OR and nibble swap.
 Assumes the sequencer issues op_valid for one cycle while op_ready is high, supplies the
 addressed data byte on mem_rdata in that cycle, and that program memory answers in the same
 cycle as prog_req.
*/
`timescale 1ns/1ps
module extop_unit
   import extop_pkg::*;
#(
   parameter int PAGE_BITS = 8
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic op_valid,
   output logic op_ready,
   input wire extop_op_t op_code,
   input wire logic [2:0] op_bit,
   input wire logic [7:0] mem_rdata,
   output logic mem_we,
   output logic [7:0] mem_wdata,
   output logic prog_req,
   output logic [PAGE_BITS+7:0] prog_addr,
   input wire logic [15:0] prog_rdata,
   input wire logic ptr_we,
   input wire logic [7:0] ptr_low_wdata,
   input wire logic [7:0] ptr_high_wdata,
   output logic [7:0] accum,
   output logic zero_flag,
   output logic [7:0] table_high_byte_reg,
   output logic [7:0] table_pointer_low,
   output logic [7:0] table_pointer_high,
   output logic skip_taken,
   output logic dummy_cycle
);
   // ***************************************************************
   // Decode helpers
   // ***************************************************************
   function automatic logic is_table(input extop_op_t op);
      is_table = (op == EXTOP_TABLE_READ_PAGE) || (op == EXTOP_TABLE_READ_LAST_PAGE) ||
                 (op == EXTOP_TABLE_READ_PAGE_PREINC) || (op == EXTOP_TABLE_READ_LAST_PREINC);
   endfunction : is_table

   function automatic logic is_preinc(input extop_op_t op);
      is_preinc = (op == EXTOP_TABLE_READ_PAGE_PREINC) || (op == EXTOP_TABLE_READ_LAST_PREINC);
   endfunction : is_preinc

   function automatic logic is_last(input extop_op_t op);
      is_last = (op == EXTOP_TABLE_READ_LAST_PAGE) || (op == EXTOP_TABLE_READ_LAST_PREINC);
   endfunction : is_last

   extop_state_t state;
   extop_state_t next_state;
   logic start;
   logic skip_cond;
   logic [7:0] xor_val;
   logic [7:0] next_ptr_low;
   logic [7:0] latched_ptr_low;
   logic [7:0] latched_ptr_high;
   logic latched_last;

   assign op_ready = (state == EXTOP_IDLE);
   assign start = op_valid && op_ready;
   assign xor_val = accum ^ mem_rdata;

   always_comb
   begin
      unique case (op_code)
         EXTOP_SKIP_IF_ZERO: skip_cond = (mem_rdata == 8'h00);
         EXTOP_SKIP_IF_ZERO_MOVE: skip_cond = (mem_rdata == 8'h00);
         EXTOP_SKIP_BIT_ZERO: skip_cond = ~mem_rdata[op_bit];
         default: skip_cond = 1'b0;
      endcase
   end

   // The increment wraps in eight bits and never carries into the high pointer.
   assign next_ptr_low = is_preinc(op_code) ? table_pointer_low + 8'h01
                                            : table_pointer_low;

   // ***************************************************************
   // Sequencer
   // ***************************************************************
   always_comb
   begin
      next_state = state;
      unique case (state)
         EXTOP_IDLE:
         begin
            if (start && is_table(op_code))
               next_state = EXTOP_TABLE_WAIT;
            else if (start && skip_cond)
               next_state = EXTOP_SKIP_DUMMY;
         end
         EXTOP_TABLE_WAIT: next_state = EXTOP_IDLE;
         EXTOP_SKIP_DUMMY: next_state = EXTOP_IDLE;
         default: next_state = EXTOP_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         state <= EXTOP_IDLE;
      else
         state <= next_state;
   end

   // The execute cycle plus one dummy cycle; the fetch of the next
   // instruction is the third cycle counted against the skip.
   assign dummy_cycle = (state == EXTOP_SKIP_DUMMY);
   assign skip_taken = start && skip_cond;

   // ***************************************************************
   // Table pointer and program-memory address
   // ***************************************************************
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         table_pointer_low <= EXTOP_PTR_RESET;
         table_pointer_high <= EXTOP_PTR_RESET;
      end
      else if (start && is_preinc(op_code))
         table_pointer_low <= next_ptr_low;
      else if (ptr_we && op_ready)
      begin
         table_pointer_low <= ptr_low_wdata;
         table_pointer_high <= ptr_high_wdata;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         latched_ptr_low <= EXTOP_PTR_RESET;
         latched_ptr_high <= EXTOP_PTR_RESET;
         latched_last <= 1'b0;
      end
      else if (start && is_table(op_code))
      begin
         latched_ptr_low <= next_ptr_low;
         latched_ptr_high <= table_pointer_high;
         latched_last <= is_last(op_code);
      end
   end

   // Address is held from flops so program memory sees a clean value.
   assign prog_req = (state == EXTOP_TABLE_WAIT);
   assign prog_addr = latched_last ? {{PAGE_BITS{1'b1}}, latched_ptr_low}
                   : {latched_ptr_high[PAGE_BITS-1:0], latched_ptr_low};

   // ***************************************************************
   // Results: accumulator, flag, table-high byte, memory write
   // ***************************************************************
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         accum <= EXTOP_ACC_RESET;
      else if (start)
      begin
         if (op_code == EXTOP_SKIP_IF_ZERO_MOVE)
            accum <= mem_rdata;
         else if (op_code == EXTOP_XOR_TO_ACCUM)
            accum <= xor_val;
         else if (op_code == EXTOP_NIBBLE_SWAP_TO_ACCUM)
            accum <= {mem_rdata[3:0], mem_rdata[7:4]};
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         zero_flag <= EXTOP_ZERO_RESET;
      else if (start && (op_code == EXTOP_XOR_TO_ACCUM || op_code == EXTOP_XOR_TO_MEMORY))
         zero_flag <= (xor_val == 8'h00);
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         table_high_byte_reg <= EXTOP_TABLE_HIGH_BYTE_REG_RESET;
      else if (state == EXTOP_TABLE_WAIT)
         table_high_byte_reg <= prog_rdata[15:8];
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         mem_we <= 1'b0;
         mem_wdata <= 8'h00;
      end
      else if (state == EXTOP_TABLE_WAIT)
      begin
         mem_we <= 1'b1;
         mem_wdata <= prog_rdata[7:0];
      end
      else if (start && op_code == EXTOP_XOR_TO_MEMORY)
      begin
         mem_we <= 1'b1;
         mem_wdata <= xor_val;
      end
      else
         mem_we <= 1'b0;
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   property p_zero_skip;
      @(posedge clk) disable iff (!rstn)
      (start && op_code == EXTOP_SKIP_IF_ZERO && mem_rdata == 8'h00) |=> dummy_cycle;
   endproperty
   a_zero_skip: assert property (p_zero_skip) else $error("zero skip not taken");

   property p_move_skip;
      @(posedge clk) disable iff (!rstn)
      (start && op_code == EXTOP_SKIP_IF_ZERO_MOVE) |=> (accum == $past(mem_rdata))
         && (dummy_cycle == ($past(mem_rdata) == 8'h00));
   endproperty
   a_move_skip: assert property (p_move_skip) else $error("move skip wrong");

   property p_bit_skip;
      @(posedge clk) disable iff (!rstn)
      (start && op_code == EXTOP_SKIP_BIT_ZERO) |=> (dummy_cycle == !$past(mem_rdata[op_bit]));
   endproperty
   a_bit_skip: assert property (p_bit_skip) else $error("bit skip wrong");

   property p_skip_len;
      @(posedge clk) disable iff (!rstn)
      skip_taken |=> !op_ready ##1 op_ready;
   endproperty
   a_skip_len: assert property (p_skip_len) else $error("skip dummy length wrong");

   property p_page_addr;
      @(posedge clk) disable iff (!rstn)
      (start && op_code == EXTOP_TABLE_READ_PAGE) |=> prog_req
         && prog_addr == {$past(table_pointer_high[PAGE_BITS-1:0]), $past(table_pointer_low)};
   endproperty
   a_page_addr: assert property (p_page_addr) else $error("page address wrong");

   property p_last_addr;
      @(posedge clk) disable iff (!rstn)
      (start && op_code == EXTOP_TABLE_READ_LAST_PAGE) |=> prog_req
         && prog_addr == {{PAGE_BITS{1'b1}}, $past(table_pointer_low)};
   endproperty
   a_last_addr: assert property (p_last_addr) else $error("last page address wrong");

   property p_preinc;
      @(posedge clk) disable iff (!rstn)
      (start && is_preinc(op_code)) |=> table_pointer_low == $past(table_pointer_low) + 8'h01
         && table_pointer_high == $past(table_pointer_high) && prog_addr[7:0] == table_pointer_low;
   endproperty
   a_preinc: assert property (p_preinc) else $error("pre-increment wrong");

   property p_preinc_last;
      @(posedge clk) disable iff (!rstn)
      (start && op_code == EXTOP_TABLE_READ_LAST_PREINC) |=>
         prog_addr == {{PAGE_BITS{1'b1}}, table_pointer_low};
   endproperty
   a_preinc_last: assert property (p_preinc_last) else $error("last preinc wrong");

   property p_xor_acc;
      @(posedge clk) disable iff (!rstn)
      (start && op_code == EXTOP_XOR_TO_ACCUM) |=> accum == ($past(accum) ^ $past(mem_rdata))
         && zero_flag == (accum == 8'h00) && !mem_we;
   endproperty
   a_xor_acc: assert property (p_xor_acc) else $error("xor to accumulator wrong");

   property p_xor_mem;
      @(posedge clk) disable iff (!rstn)
      (start && op_code == EXTOP_XOR_TO_MEMORY) |=> mem_we && $stable(accum)
         && mem_wdata == ($past(accum) ^ $past(mem_rdata)) && zero_flag == (mem_wdata == 8'h00);
   endproperty
   a_xor_mem: assert property (p_xor_mem) else $error("xor to memory wrong");

   property p_swap;
      @(posedge clk) disable iff (!rstn)
      (start && op_code == EXTOP_NIBBLE_SWAP_TO_ACCUM) |=>
         accum == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])} && $stable(zero_flag) && !mem_we;
   endproperty
   a_swap: assert property (p_swap) else $error("nibble swap wrong");

   property p_table_flags;
      @(posedge clk) disable iff (!rstn)
      (start && is_table(op_code)) |=> $stable(zero_flag) ##1 ($stable(zero_flag) && mem_we);
   endproperty
   a_table_flags: assert property (p_table_flags) else $error("table read flags");

   c_skip: cover property (@(posedge clk) disable iff (!rstn) skip_taken ##1 dummy_cycle);
   c_table: cover property (@(posedge clk) disable iff (!rstn) prog_req ##1 mem_we);
   c_xor_zero: cover property (@(posedge clk) disable iff (!rstn)
      start && op_code == EXTOP_XOR_TO_ACCUM && xor_val == 8'h00);
   c_wrap: cover property (@(posedge clk) disable iff (!rstn)
      start && is_preinc(op_code) && table_pointer_low == 8'hff);
endmodule : extop_unit

// [tb_ext_skip_table_xor_ops.sv]
/*
 Self-checking testbench for the extended skip, table-read and exclusive-OR unit.
 Assumes a combinational program memory answer in the prog_req cycle, driven here by the bench.
*/
`timescale 1ns/1ps
module tb_ext_skip_table_xor_ops
   import extop_pkg::*;
;
   logic clk, rstn, op_valid, op_ready, mem_we, prog_req, ptr_we, zero_flag;
   logic skip_taken, dummy_cycle;
   extop_op_t op_code;
   logic [2:0] op_bit;
   logic [7:0] mem_rdata, mem_wdata, ptr_low_wdata, ptr_high_wdata, accum;
   logic [7:0] table_high_byte_reg, table_pointer_low, table_pointer_high;
   logic [15:0] prog_addr, prog_rdata;
   logic exp_z;
   int bad_count = 0;
   int checked = 0;

   extop_unit dut (.clk(clk), .rstn(rstn), .op_valid(op_valid), .op_ready(op_ready),
      .op_code(op_code), .op_bit(op_bit), .mem_rdata(mem_rdata), .mem_we(mem_we),
      .mem_wdata(mem_wdata), .prog_req(prog_req), .prog_addr(prog_addr),
      .prog_rdata(prog_rdata), .ptr_we(ptr_we), .ptr_low_wdata(ptr_low_wdata),
      .ptr_high_wdata(ptr_high_wdata), .accum(accum), .zero_flag(zero_flag),
      .table_high_byte_reg(table_high_byte_reg), .table_pointer_low(table_pointer_low),
      .table_pointer_high(table_pointer_high), .skip_taken(skip_taken),
      .dummy_cycle(dummy_cycle));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic stop_test;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // ***************************************************************
   // Issue one operation; entered and left just after a falling edge
   // ***************************************************************
   task automatic issue(input extop_op_t op, input logic [7:0] bv, input logic [2:0] bit_v,
      output logic skip_seen);
      int n;
      n = 0;
      // One clock edge passes first, so a request is never lowered and raised in one step.
      @(negedge clk);
      while (op_ready !== 1'b1)
      begin
         @(negedge clk);
         n++;
         if (n > 20)
         begin
            bad_count++;
            stop_test();
         end
      end
      op_valid = 1'b1;
      op_code = op;
      mem_rdata = bv;
      op_bit = bit_v;
      #1 skip_seen = skip_taken;
      @(posedge clk);
      @(negedge clk);
      op_valid = 1'b0;
      op_code = EXTOP_NONE;
      mem_rdata = ~bv;
   endtask : issue

   task automatic t_xor;
      logic s;
      issue(EXTOP_XOR_TO_ACCUM, 8'h5a, 3'h0, s);
      chk({accum, zero_flag, mem_we}, {8'h5a, 2'b00});
      issue(EXTOP_XOR_TO_ACCUM, 8'h5a, 3'h0, s);
      chk({accum, zero_flag, mem_we}, {8'h00, 2'b10});
      issue(EXTOP_XOR_TO_MEMORY, 8'h0f, 3'h0, s);
      chk({mem_we, mem_wdata, zero_flag, accum}, {1'b1, 8'h0f, 1'b0, 8'h00});
      issue(EXTOP_XOR_TO_MEMORY, 8'h00, 3'h0, s);
      chk({mem_we, mem_wdata, zero_flag, accum}, {1'b1, 8'h00, 1'b1, 8'h00});
      exp_z = 1'b1;
      $display("test xor done");
   endtask : t_xor

   task automatic t_skip;
      logic s;
      issue(EXTOP_SKIP_IF_ZERO, 8'h00, 3'h0, s);
      chk({s, dummy_cycle, op_ready, zero_flag}, {3'b110, exp_z});
      @(negedge clk);
      chk({dummy_cycle, op_ready}, 2'b01);
      issue(EXTOP_SKIP_IF_ZERO, 8'h80, 3'h0, s);
      chk({s, dummy_cycle, op_ready}, 3'b001);
      issue(EXTOP_SKIP_IF_ZERO_MOVE, 8'h00, 3'h0, s);
      chk({s, dummy_cycle, accum, zero_flag}, {2'b11, 8'h00, exp_z});
      @(negedge clk);
      issue(EXTOP_SKIP_IF_ZERO_MOVE, 8'ha5, 3'h0, s);
      chk({s, dummy_cycle, accum, zero_flag}, {2'b00, 8'ha5, exp_z});
      $display("test skip done");
   endtask : t_skip

   task automatic t_bit;
      logic s;
      for (int b = 0; b < 8; b++)
      begin
         issue(EXTOP_SKIP_BIT_ZERO, ~(8'h01 << b), 3'(b), s);
         chk({s, dummy_cycle, zero_flag}, {2'b11, exp_z});
         @(negedge clk);
         issue(EXTOP_SKIP_BIT_ZERO, ~(8'h01 << b), 3'(b + 1), s);
         chk({s, dummy_cycle}, 2'b00);
      end
      $display("test bit skip done");
   endtask : t_bit

   task automatic t_swap;
      logic s;
      issue(EXTOP_NIBBLE_SWAP_TO_ACCUM, 8'h3c, 3'h0, s);
      chk({accum, mem_we, zero_flag}, {8'hc3, 1'b0, exp_z});
      $display("test swap done");
   endtask : t_swap

   task automatic tread(input extop_op_t op, input logic [15:0] addr, input logic [15:0] word);
      logic s;
      issue(op, 8'h00, 3'h0, s);
      chk({prog_req, op_ready}, 2'b10);
      chk(prog_addr, addr);
      prog_rdata = word;
      @(negedge clk);
      chk({mem_we, mem_wdata, table_high_byte_reg}, {1'b1, word[7:0], word[15:8]});
      chk(zero_flag, exp_z);
      prog_rdata = ~word;
   endtask : tread

   task automatic t_table;
      ptr_high_wdata = 8'h12;
      ptr_low_wdata = 8'hfe;
      ptr_we = 1'b1;
      @(negedge clk);
      ptr_we = 1'b0;
      chk({table_pointer_high, table_pointer_low}, 16'h12fe);
      tread(EXTOP_TABLE_READ_PAGE, 16'h12fe, 16'ha1b2);
      tread(EXTOP_TABLE_READ_LAST_PAGE, 16'hfffe, 16'h3c4d);
      tread(EXTOP_TABLE_READ_PAGE_PREINC, 16'h12ff, 16'h5e6f);
      tread(EXTOP_TABLE_READ_LAST_PREINC, 16'hff00, 16'h7081);
      chk({table_pointer_high, table_pointer_low}, 16'h1200);
      $display("test table done");
   endtask : t_table

   initial
   begin
      rstn = 1'b0;
      op_valid = 1'b0;
      op_code = EXTOP_NONE;
      op_bit = 3'h0;
      mem_rdata = 8'h00;
      prog_rdata = 16'h0000;
      ptr_we = 1'b0;
      ptr_low_wdata = 8'h00;
      ptr_high_wdata = 8'h00;
      exp_z = 1'b0;
      repeat (12) @(negedge clk);
      rstn = 1'b1;
      chk({accum, zero_flag, op_ready, table_high_byte_reg}, {8'h00, 2'b01, 8'h00});
      t_xor();
      t_skip();
      t_bit();
      t_swap();
      t_table();
      stop_test();
   end
endmodule : tb_ext_skip_table_xor_ops
